//--- design/opdec_pkg.sv
/*
  constants, field positions and carrier types for the operand decoder and
  address generator of the 16-bit core.
  assumes one clock domain and a unified 16-bit byte-addressed memory.
*/
package opdec_pkg;

  // ------------------------------------------------------------------
  // addresses and reset values
  // ------------------------------------------------------------------
  localparam logic [15:0] RESET_VECTOR = 16'hfff0;
  localparam logic [15:0] OFS_FLAGS    = 16'hc000;
  localparam logic [15:0] OFS_BASE     = 16'hc002;
  localparam logic [15:0] BASE_RESET   = 16'h0100;
  localparam int          BASE_LSB     = 5;        // bits below are ignored
  localparam logic [3:0]  SP_NUM       = 4'hf;
  localparam logic        PTR_BANK     = 1'b1;     // pointer regs are 8..15
  localparam logic [15:0] WORD_STEP    = 16'h0002;
  localparam logic [15:0] BYTE_STEP    = 16'h0001;

  // ------------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------------
  localparam int OPC_LSB = 12;
  localparam int SRC_LSB = 6;
  localparam int DST_LSB = 0;
  localparam int FLAG_Z  = 0;
  localparam int FLAG_C  = 1;
  localparam int FLAG_S  = 3;
  localparam int FLAG_I  = 4;

  // ------------------------------------------------------------------
  // types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    MODE_REG  = 3'b000,
    MODE_IMM  = 3'b001,
    MODE_DIR  = 3'b010,
    MODE_IND  = 3'b011,
    MODE_AINC = 3'b100,
    MODE_IDX  = 3'b101
  } mode_t;

  typedef struct packed {
    mode_t       mode;
    logic        byte_wide;
    logic [15:0] addr;
    logic [15:0] value;
  } operand_t;

  typedef struct packed {
    logic [3:0] opcode;
    operand_t   src;
    operand_t   dst;
  } decoded_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mem_req_t;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } reg_bus_t;

  typedef struct packed {
    logic        update;
    logic [15:0] result;
    logic        carry;
    logic        overflow;
    logic        int_set;
    logic        int_clr;
  } flag_upd_t;

  typedef struct packed {
    logic z;
    logic c;
    logic o;
    logic s;
    logic i;
  } flags_t;

endpackage

//--- design/operand_decoder.sv
/*
  operand decode and address generation: fetches each instruction word,
  decodes source then destination operand fields, fetches extension words,
  reads pointer registers out of the ram window and writes them back after
  auto-increment or stack push/pop; holds the flags and window base regs.
  assumes memory returns read data in the cycle after mem.rd, never stalls,
  and that the execution side pulses exec_done once it has used the result.
*/
// Operation
// - after reset the first instruction fetch is from address fff0
// - registers 0..14 are general storage, register 15 is the stack pointer
// - registers 8..15 can act as memory pointers for operand fields
// - register ram address is base upper bits, number shifted left, bit0 zero
// - low five bits of the window base never reach the address
// - window base resets to 0100, so register 14 sits at 011c
// - flags read only: zero bit0, carry bit1, sign bit3, interrupt bit4
// - zero means zero result, sign copies msb, interrupt flag enables interrupts
// - carry records carry or borrow, overflow records out-of-range result
// - opcode in bits 15..12, source field 11..6, destination field 5..0
// - field decode into register, immediate, direct and three indirect modes
// - in direct and indirect modes bit 3 set means byte, clear means word
// - byte indirect and auto-increment via register 15 become immediate/direct
// - register operands are always full words
// - immediate operand is the next word and always word sized
// - direct mode takes the next word as operand address, width from bit 3
// - source extension word is fetched before destination extension word
// - indirect selects pointer 8..15 by low three bits, bit 3 is width
// - auto-increment adds 1 for byte or 2 for word after the access
// - indexed mode adds next word to pointer, wrapping modulo 64k
// - stack pointer indirect: decrement before write, increment after read
// - stack pointer in indexed mode is left unchanged
`timescale 1ns/10ps

module operand_decoder (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // register port
  input  wire opdec_pkg::reg_bus_t  bus,
  output      logic [15:0]          rdata,
  // unified memory
  output      opdec_pkg::mem_req_t  mem,
  input  wire logic [15:0]          mem_rdata,
  // execution side
  output      logic                 dec_valid,
  output      opdec_pkg::decoded_t  dec,
  input  wire logic                 exec_done,
  input  wire opdec_pkg::flag_upd_t upd,
  output      opdec_pkg::flags_t    flags
);
  import opdec_pkg::*;

  // ------------------------------------------------------------------
  // state
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_FETCH   = 3'b000,
    ST_IWAIT   = 3'b001,
    ST_OPER    = 3'b010,
    ST_EXTWAIT = 3'b011,
    ST_PTRWAIT = 3'b100,
    ST_DONE    = 3'b101
  } state_t;

  typedef struct packed {
    state_t      state;
    logic        armed;
    logic        which;     // 0 source, 1 destination
    logic        have_ext;
    logic        have_ptr;
    logic [15:0] pc;
    logic [15:0] ir;
    logic [15:0] ext;
    logic [15:0] ptr;
    logic [15:0] bank;
    flags_t      flags;
    mem_req_t    mem;
    logic [15:0] rdata;
    logic        dec_valid;
    decoded_t    dec;
  } st_t;

  st_t s;
  st_t next_s;

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // register number to its word in the ram window
  function automatic logic [15:0] reg_loc(input logic [15:0] base,
                                          input logic [3:0]  num);
    return {base[15:BASE_LSB], num, 1'b0};
  endfunction

  // one six-bit operand field to its addressing mode
  function automatic mode_t field_mode(input logic [5:0] f);
    mode_t m;
    m = MODE_REG;
    case (f[5:4])
      2'b00: m = MODE_REG;
      2'b01: m = (f[3:0] == 4'hf) ? MODE_IMM : MODE_IND;
      2'b10: m = (f[2:0] == 3'b111) ? MODE_DIR : MODE_AINC;
      2'b11: m = MODE_IDX;
      default: m = MODE_REG;
    endcase
    return m;
  endfunction

  // ------------------------------------------------------------------
  // next-state logic
  // ------------------------------------------------------------------
  logic [5:0]  fld;
  mode_t       mode;
  logic        bw;
  logic [3:0]  num;
  logic [15:0] new_ptr;
  logic        upd_ptr;
  operand_t    op;

  always_comb begin
    next_s            = s;
    next_s.mem.rd     = 1'b0;
    next_s.mem.wr     = 1'b0;
    next_s.dec_valid  = 1'b0;
    next_s.rdata      = 16'h0000;
    fld      = s.which ? s.ir[DST_LSB +: 6] : s.ir[SRC_LSB +: 6];
    mode     = field_mode(fld);
    // register and immediate never carry a width bit
    bw       = (mode == MODE_REG || mode == MODE_IMM) ? 1'b0 : fld[3];
    num      = (mode == MODE_REG) ? fld[3:0] : {PTR_BANK, fld[2:0]};
    new_ptr  = s.ptr;
    upd_ptr  = 1'b0;
    op       = '0;

    // register port: reads answer one cycle later, only there
    if (bus.rd) begin
      if (bus.addr == OFS_FLAGS) begin
        next_s.rdata[FLAG_Z] = s.flags.z;
        next_s.rdata[FLAG_C] = s.flags.c;
        next_s.rdata[FLAG_S] = s.flags.s;
        next_s.rdata[FLAG_I] = s.flags.i;
      end else if (bus.addr == OFS_BASE) begin
        next_s.rdata = s.bank;
      end
    end
    if (bus.wr && bus.addr == OFS_BASE) begin
      next_s.bank = bus.wdata;  // all bits stored, low five unused
    end

    // flag update from the execution side
    if (upd.update) begin
      next_s.flags.z = (upd.result == 16'h0000);
      next_s.flags.s = upd.result[15];
      next_s.flags.c = upd.carry;
      next_s.flags.o = upd.overflow;
    end
    if (upd.int_set) begin
      next_s.flags.i = 1'b1;
    end else if (upd.int_clr) begin
      next_s.flags.i = 1'b0;
    end

    case (s.state)
      ST_FETCH: begin
        next_s.mem.rd   = 1'b1;
        next_s.mem.addr = s.pc;
        next_s.pc       = s.pc + WORD_STEP;
        next_s.armed    = 1'b0;
        next_s.state    = ST_IWAIT;
      end
      ST_IWAIT: begin
        // first cycle: request on the pins, second: data back
        next_s.armed = ~s.armed;
        if (s.armed) begin
          next_s.ir       = mem_rdata;
          next_s.which    = 1'b0;
          next_s.have_ext = 1'b0;
          next_s.have_ptr = 1'b0;
          next_s.state    = ST_OPER;
        end
      end
      ST_OPER: begin
        // source is finished before destination starts, so its
        // extension word is taken from the stream first
        if ((mode == MODE_IMM || mode == MODE_DIR || mode == MODE_IDX) && !s.have_ext) begin
          next_s.mem.rd   = 1'b1;
          next_s.mem.addr = s.pc;
          next_s.pc       = s.pc + WORD_STEP;
          next_s.armed    = 1'b0;
          next_s.state    = ST_EXTWAIT;
        end else if ((mode == MODE_IND || mode == MODE_AINC || mode == MODE_IDX)
                     && !s.have_ptr) begin
          next_s.mem.rd   = 1'b1;
          next_s.mem.addr = reg_loc(s.bank, num);
          next_s.armed    = 1'b0;
          next_s.state    = ST_PTRWAIT;
        end else begin
          op.mode      = mode;
          op.byte_wide = bw;
          case (mode)
            MODE_REG:  op.addr = reg_loc(s.bank, num);
            MODE_IMM: begin
              op.addr  = s.pc - WORD_STEP;
              op.value = s.ext;
            end
            MODE_DIR:  op.addr = s.ext;
            MODE_IND: begin
              op.addr = s.ptr;
              if (num == SP_NUM) begin
                upd_ptr = 1'b1;
                if (s.which) begin
                  new_ptr = s.ptr - WORD_STEP;
                  op.addr = new_ptr;
                end else begin
                  new_ptr = s.ptr + WORD_STEP;
                end
              end
            end
            MODE_AINC: begin
              op.addr = s.ptr;
              upd_ptr = 1'b1;
              new_ptr = s.ptr + (bw ? BYTE_STEP : WORD_STEP);
            end
            MODE_IDX:  op.addr = s.ptr + s.ext;
            default:   op.addr = 16'h0000;
          endcase
          op.value = (mode == MODE_IMM) ? s.ext : 16'h0000;
          if (upd_ptr) begin
            next_s.mem.wr    = 1'b1;
            next_s.mem.addr  = reg_loc(s.bank, num);
            next_s.mem.wdata = new_ptr;
          end
          next_s.have_ext = 1'b0;
          next_s.have_ptr = 1'b0;
          if (s.which) begin
            next_s.dec.dst    = op;
            next_s.dec.opcode = s.ir[OPC_LSB +: 4];
            next_s.dec_valid  = 1'b1;
            next_s.state      = ST_DONE;
          end else begin
            next_s.dec.src = op;
            next_s.which   = 1'b1;
          end
        end
      end
      ST_EXTWAIT: begin
        next_s.armed = ~s.armed;
        if (s.armed) begin
          next_s.ext      = mem_rdata;
          next_s.have_ext = 1'b1;
          next_s.state    = ST_OPER;
        end
      end
      ST_PTRWAIT: begin
        next_s.armed = ~s.armed;
        if (s.armed) begin
          next_s.ptr      = mem_rdata;
          next_s.have_ptr = 1'b1;
          next_s.state    = ST_OPER;
        end
      end
      ST_DONE: begin
        if (exec_done) begin
          next_s.state = ST_FETCH;
        end
      end
      default: next_s.state = ST_FETCH;
    endcase
  end

  // ------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------
  // reset restarts at the vector with default window base
  always_ff @(posedge clk) begin
    if (rst) begin
      s       <= '0;
      s.state <= ST_FETCH;
      s.pc    <= RESET_VECTOR;
      s.bank  <= BASE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from the state flops
  assign rdata     = s.rdata;
  assign mem       = s.mem;
  assign dec_valid = s.dec_valid;
  assign dec       = s.dec;
  assign flags     = s.flags;

  // ------------------------------------------------------------------
  // checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  reset_fetch_a: assert property ($fell(rst) |=> mem.rd && mem.addr == RESET_VECTOR)
    else $error("first fetch not at reset vector");
  bank_default_a: assert property ($fell(rst) |-> s.bank == BASE_RESET)
    else $error("window base reset value wrong");
  reg_map_a: assert property (dec_valid && dec.dst.mode == MODE_REG
    |-> dec.dst.addr[4:0] == {s.ir[3:0], 1'b0})
    else $error("register window address wrong");
  flags_read_a: assert property (bus.rd && bus.addr == OFS_FLAGS
    |=> rdata[15:5] == 11'h000 && rdata[2] == 1'b0 && rdata[0] == $past(s.flags.z))
    else $error("flags readback layout wrong");
  zero_sign_a: assert property (upd.update
    |=> flags.z == ($past(upd.result) == 16'h0000) && flags.s == $past(upd.result[15]))
    else $error("zero or sign flag wrong");
  imm_word_a: assert property (s.state == ST_OPER && !s.which && mode == MODE_IMM
    && s.have_ext |=> !dec.src.byte_wide && dec.src.value == $past(s.ext))
    else $error("immediate operand not a word");
  reg_word_a: assert property (dec_valid && dec.src.mode == MODE_REG
    |-> !dec.src.byte_wide)
    else $error("register operand not word wide");
  sp_alias_a: assert property (dec_valid
    |-> (s.ir[5:0] == 6'b011111) == (dec.dst.mode == MODE_IMM))
    else $error("stack byte indirect not decoded as immediate");
  ext_read_a: assert property (s.state == ST_EXTWAIT && !s.armed
    |-> mem.rd && mem.addr == s.pc - WORD_STEP)
    else $error("extension word not taken from stream");

  // field decode and window placement; base may change later, so use the one in force
  window_addr_a: assert property (dec_valid && dec.dst.mode == MODE_REG
    |-> dec.dst.addr == {$past(s.bank[15:BASE_LSB]), s.ir[3:0], 1'b0})
    else $error("register window address ignores base wrongly");
  ptr_bank_a: assert property (s.state == ST_PTRWAIT && mem.rd
    |-> mem.addr[4] == PTR_BANK && mem.addr[0] == 1'b0)
    else $error("pointer read outside registers eight to fifteen");
  width_bit_a: assert property (dec_valid
    && dec.dst.mode inside {MODE_DIR, MODE_IND, MODE_AINC, MODE_IDX}
    |-> dec.dst.byte_wide == s.ir[3])
    else $error("access width does not follow bit three");
  opcode_field_a: assert property (dec_valid |-> dec.opcode == s.ir[OPC_LSB +: 4])
    else $error("opcode not taken from the top bits");

  // pointer arithmetic: one write-back per update, none for plain or indexed
  ainc_step_a: assert property (s.state == ST_OPER && mode == MODE_AINC
    && s.have_ptr
    |=> mem.wr && mem.wdata == $past(s.ptr) + ($past(bw) ? BYTE_STEP : WORD_STEP))
    else $error("auto-increment step wrong");
  pop_step_a: assert property (s.state == ST_OPER && mode == MODE_IND && num == SP_NUM
    && s.have_ptr && !s.which
    |=> mem.wr && mem.wdata == $past(s.ptr) + WORD_STEP && dec.src.addr == $past(s.ptr))
    else $error("stack pop did not post-increment by two");
  push_step_a: assert property (s.state == ST_OPER && mode == MODE_IND && num == SP_NUM
    && s.have_ptr && s.which
    |=> mem.wr && mem.wdata == $past(s.ptr) - WORD_STEP && dec.dst.addr == mem.wdata)
    else $error("stack push did not pre-decrement by two");
  ind_addr_a: assert property (s.state == ST_OPER && mode == MODE_IND && num != SP_NUM
    && s.have_ptr
    |=> !mem.wr && ($past(s.which) ? dec.dst.addr : dec.src.addr) == $past(s.ptr))
    else $error("indirect operand not at pointer");
  idx_keep_a: assert property (s.state == ST_OPER && mode == MODE_IDX && s.have_ptr
    |=> !mem.wr)
    else $error("indexed mode changed its pointer");
  idx_sum_a: assert property (s.state == ST_OPER && mode == MODE_IDX && s.have_ptr
    |=> ($past(s.which) ? dec.dst.addr : dec.src.addr) == $past(s.ptr) + $past(s.ext))
    else $error("indexed address not pointer plus offset");
  dir_addr_a: assert property (s.state == ST_OPER && mode == MODE_DIR && s.have_ext
    |=> ($past(s.which) ? dec.dst.addr : dec.src.addr) == $past(s.ext))
    else $error("direct operand address not the extension word");

  // register port and flag behaviour
  base_read_a: assert property (bus.rd && bus.addr == OFS_BASE
    |=> rdata == $past(s.bank))
    else $error("window base readback wrong");
  carry_ovf_a: assert property (upd.update
    |=> flags.c == $past(upd.carry) && flags.o == $past(upd.overflow))
    else $error("carry or overflow flag wrong");
  int_enable_a: assert property (upd.int_set |=> flags.i == 1'b1)
    else $error("interrupt enable flag not set");

endmodule

//--- test/mem_model.sv
/*
  unified program and data memory seen by the operand decoder.
  assumes requests are one-cycle pulses and read data is wanted in the
  cycle after the read request, with no wait states.
*/
`timescale 1ns/10ps

module mem_model (
  // clock
  input  wire logic                clk,
  // request side
  input  wire opdec_pkg::mem_req_t mem,
  output      logic [15:0]         mem_rdata
);
  import opdec_pkg::*;
  logic [15:0] ram [0:32767];

  // ------------------------------------------------------------------
  // word access, answered one cycle after the read
  // ------------------------------------------------------------------
  initial mem_rdata = 16'h0000;

  // outside a read slot the data toggle, so stale data never look valid;
  // plain always, since the bench preloads the array from outside
  always @(posedge clk) begin
    if (mem.wr) begin
      ram[mem.addr[15:1]] <= mem.wdata;
    end
    if (mem.rd) begin
      mem_rdata <= ram[mem.addr[15:1]];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule

//--- test/tb_top.sv
/*
  self-checking bench for the operand decoder: register port, reset
  fetch, all operand modes, pointer updates and flag readback.
  assumes the memory model in mem_model.sv and a 125 MHz clock.
*/
`timescale 1ns/10ps

module tb_top;
  import opdec_pkg::*;
  logic        clk;
  logic        rst;
  reg_bus_t    bus;
  logic [15:0] rdata;
  mem_req_t    mem;
  logic [15:0] mem_rdata;
  logic        dec_valid;
  decoded_t    dec;
  logic        exec_done;
  flag_upd_t   upd;
  flags_t      flags;
  int          fail_count;
  int          check_count;
  int          cycles;
  int          dec_count;
  int          dec_taken;

  operand_decoder dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .mem(mem),
    .mem_rdata(mem_rdata), .dec_valid(dec_valid), .dec(dec), .exec_done(exec_done),
    .upd(upd), .flags(flags));
  mem_model u_mem (.clk(clk), .mem(mem), .mem_rdata(mem_rdata));

  // ------------------------------------------------------------------
  // clock and hang guard
  // ------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // the whole run is well under two hundred cycles; 3000 means something hung
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      fail_count = fail_count + 1;
      give_verdict();
    end
  end

  // decode pulses are counted mid-cycle, so one that falls inside another task is not lost
  always @(negedge clk) begin
    if (dec_valid === 1'b1) begin
      dec_count = dec_count + 1;
    end
  end

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    check_count = check_count + 1;
    if (seen !== exp) begin
      fail_count = fail_count + 1;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    bus <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    bus <= '0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [15:0] a, output logic [15:0] d);
    @(posedge clk);
    bus <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge clk);
    bus <= '0;
    #1 d = rdata;
  endtask

  task automatic poke(input logic [15:0] a, input logic [15:0] d);
    u_mem.ram[a[15:1]] = d;
  endtask

  task automatic wait_dec();
    for (int i = 0; i < 40; i++) begin
      if (dec_count > dec_taken) break;
      @(posedge clk);
      #1;
    end
    check("dec_valid", {15'h0000, dec_count > dec_taken}, 16'h0001);
    dec_taken = dec_taken + 1;
  endtask

  task automatic release_dec();
    @(posedge clk);
    exec_done <= 1'b1;
    @(posedge clk);
    exec_done <= 1'b0;
  endtask

  task automatic check_op(input string n, input operand_t o, input mode_t m,
                          input logic b, input logic [15:0] a, input logic [15:0] v);
    check({n, " mode"}, {13'h0000, o.mode}, {13'h0000, m});
    check({n, " byte"}, {15'h0000, o.byte_wide}, {15'h0000, b});
    check({n, " addr"}, o.addr, a);
    check({n, " value"}, o.value, v);
  endtask

  // ------------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------------
  task automatic test_reset_regs();
    logic [15:0] d;
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      #1 if (mem.rd === 1'b1) break;
    end
    check("first fetch rd", {15'h0000, mem.rd}, 16'h0001);
    check("first fetch", mem.addr, 16'hfff0);
    reg_rd(16'hc002, d);
    check("base reset", d, 16'h0100);
    reg_wr(16'hc000, 16'hffff);
    reg_rd(16'hc000, d);
    check("flags read only", d, 16'h0000);
    reg_rd(16'hc004, d);
    check("unmapped read", d, 16'h0000);
    $display("test reset_regs done");
  endtask

  task automatic test_register_mode();
    logic [15:0] d;
    wait_dec();
    check("opcode", {12'h000, dec.opcode}, 16'h0001);
    check_op("r14", dec.src, MODE_REG, 1'b0, 16'h011c, 16'h0000);
    check_op("r7", dec.dst, MODE_REG, 1'b0, 16'h010e, 16'h0000);
    reg_wr(16'hc002, 16'h021f);
    reg_rd(16'hc002, d);
    check("base write", d, 16'h021f);
    release_dec();
    $display("test register_mode done");
  endtask

  task automatic test_ext_words();
    wait_dec();
    check("opcode", {12'h000, dec.opcode}, 16'h0002);
    check_op("imm", dec.src, MODE_IMM, 1'b0, 16'hfff4, 16'ha5a5);
    check_op("dir", dec.dst, MODE_DIR, 1'b1, 16'h1234, 16'h0000);
    release_dec();
    $display("test ext_words done");
  endtask

  task automatic test_ainc_index();
    wait_dec();
    check_op("ainc", dec.src, MODE_AINC, 1'b1, 16'h3000, 16'h0000);
    check_op("idx", dec.dst, MODE_IDX, 1'b0, 16'h5010, 16'h0000);
    check("r9 after", u_mem.ram[16'h0109], 16'h3001);
    check("sp after idx", u_mem.ram[16'h010f], 16'h5000);
    release_dec();
    $display("test ainc_index done");
  endtask

  task automatic test_stack();
    wait_dec();
    check_op("pop", dec.src, MODE_IND, 1'b0, 16'h5000, 16'h0000);
    check_op("r10", dec.dst, MODE_IND, 1'b1, 16'h6000, 16'h0000);
    check("sp after pop", u_mem.ram[16'h010f], 16'h5002);
    release_dec();
    wait_dec();
    check_op("r8", dec.src, MODE_REG, 1'b0, 16'h0210, 16'h0000);
    check_op("push", dec.dst, MODE_IND, 1'b0, 16'h5000, 16'h0000);
    check("sp after push", u_mem.ram[16'h010f], 16'h5000);
    release_dec();
    $display("test stack done");
  endtask

  task automatic test_flags();
    logic [15:0] d;
    @(posedge clk);
    upd <= '{update: 1'b1, result: 16'h0000, carry: 1'b1, overflow: 1'b0,
             int_set: 1'b1, int_clr: 1'b0};
    @(posedge clk);
    upd <= '0;
    reg_rd(16'hc000, d);
    check("flags zero", d, 16'h0013);
    @(posedge clk);
    upd <= '{update: 1'b1, result: 16'h8000, carry: 1'b0, overflow: 1'b1,
             int_set: 1'b0, int_clr: 1'b1};
    @(posedge clk);
    upd <= '0;
    reg_rd(16'hc000, d);
    check("flags sign", d, 16'h0008);
    check("overflow", {15'h0000, flags.o}, 16'h0001);
    $display("test flags done");
  endtask

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    rst = 1'b1;
    bus = '0;
    exec_done = 1'b0;
    upd = '0;
    fail_count = 0;
    check_count = 0;
    cycles = 0;
    // program from the reset vector, then the pointer words in the window
    poke(16'hfff0, 16'h1387);
    poke(16'hfff2, 16'h27ef);
    poke(16'hfff4, 16'ha5a5);
    poke(16'hfff6, 16'h1234);
    poke(16'hfff8, 16'h3a77);
    poke(16'hfffa, 16'h0010);
    poke(16'hfffc, 16'h45da);
    poke(16'hfffe, 16'h5217);
    // the pc wraps to zero after the last word; a register move keeps that tail defined
    poke(16'h0000, 16'h0000);
    poke(16'h0212, 16'h3000);
    poke(16'h0214, 16'h6000);
    poke(16'h021e, 16'h5000);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    test_reset_regs();
    test_register_mode();
    test_ext_words();
    test_ainc_index();
    test_stack();
    test_flags();
    give_verdict();
  end
endmodule
